// ===== ppm_cfg.svh
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// ****************************************************************
// Register indices (byte address is the index times four)
// ****************************************************************
`define PPM_IDX_A_DATA      9'h000
`define PPM_IDX_E_DATA      9'h001
`define PPM_IDX_A_DIR       9'h002
`define PPM_IDX_E_DIR       9'h003
`define PPM_IDX_RSVD_LO     9'h004
`define PPM_IDX_PULL        9'h00C
`define PPM_IDX_DRIVE       9'h00D
`define PPM_IDX_A_LEVEL     9'h120
`define PPM_IDX_E_LEVEL     9'h121
`define PPM_IDX_RSVD_HI     9'h122

// ****************************************************************
// Bus geometry
// ****************************************************************
`define PPM_ADDR_W          11
`define PPM_IDX_W           9

// ****************************************************************
// Port widths
// ****************************************************************
`define PPM_GROUP_A_W       8
`define PPM_GROUP_E_W       2
`define PPM_SPI_W           4

// ****************************************************************
// Field positions
// ****************************************************************
`define PPM_PULL_DBG_PU_BIT 6
`define PPM_PULL_E_PD_BIT   1
`define PPM_DRV_D_BIT       3
`define PPM_DRV_C_BIT       2
`define PPM_SPI_SS_BIT      3

// ****************************************************************
// Reset values
// ****************************************************************
`define PPM_RST_A_BYTE      8'h00
`define PPM_RST_E_BITS      2'h0
`define PPM_RST_DBG_PU      1'b0
`define PPM_RST_E_PD        1'b0
`define PPM_RST_D_RD        1'b0
`define PPM_RST_C_RD        1'b0

`endif

// ===== ppm_pin_model.sv
`default_nettype none

// ****************************************************************
// Outside world seen by the port pins
// ****************************************************************
module ppm_pin_model (
    // Design drive
    input  wire logic [9:0] pin_o_i,
    input  wire logic [9:0] pin_oe_i,
    // Outside source when the design lets go
    input  wire logic [9:0] ext_i,
    // Resolved pad level
    output logic      [9:0] pin_i_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Driven pins follow the design, released ones the outside source
    assign pin_i_o = (pin_o_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule // ppm_pin_model

`default_nettype wire

// ===== ppm_pin_mux.sv
`default_nettype none

// ****************************************************************
// Per-pin function selector
// ****************************************************************
module ppm_pin_mux #(
    parameter int W = 10
) (
    // General-purpose side
    input  wire logic [W-1:0] gpio_out_i,
    input  wire logic [W-1:0] gpio_dir_i,
    // Alternative function side
    input  wire logic [W-1:0] alt_sel_i,
    input  wire logic [W-1:0] alt_out_i,
    input  wire logic [W-1:0] alt_oe_i,
    // Next pin drive
    output logic      [W-1:0] pin_out_o,
    output logic      [W-1:0] pin_oe_o
);

    // One selector per pin
    for (genvar i = 0; i < W; i++) begin : g_pin
        assign pin_out_o[i] = alt_sel_i[i] ? alt_out_i[i] : gpio_out_i[i];
        assign pin_oe_o[i]  = alt_sel_i[i] ? alt_oe_i[i]  : gpio_dir_i[i];
    end

endmodule // ppm_pin_mux

`default_nettype wire

// ===== ppm_pkg.sv
`default_nettype none

// ****************************************************************
// Shared types
// ****************************************************************
package ppm_pkg;

    // All ten pins, group E above group A
    typedef logic [9:0] ppm_pins_t;

    // Two-stage synchroniser state
    typedef struct packed {
        ppm_pins_t meta;
        ppm_pins_t stable;
    } ppm_sync_s;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0]  a_data;
        logic [1:0]  e_data;
        logic [7:0]  a_dir;
        logic [1:0]  e_dir;
        logic        dbg_pu;
        logic        e_pd;
        logic        d_rd;
        logic        c_rd;
        logic [31:0] rdata;
        ppm_pins_t   pin_out;
        ppm_pins_t   pin_oe;
        logic [1:0]  osc_conn;
    } ppm_state_s;

endpackage : ppm_pkg

`default_nettype wire

// ===== ppm_port_mux_gpio.sv
// Local design decision: the APB interface to the registers.
`default_nettype none
`include "ppm_cfg.svh"

// ****************************************************************
// Port pin multiplexer and general-purpose I/O
// ****************************************************************

module ppm_port_mux_gpio (
    // Clock and reset
    input  wire logic                      CORE_CLK_I,
    input  wire logic                      SYS_RST_I,

    // APB slave
    input  wire logic                      PSEL_I,
    input  wire logic                      PENABLE_I,
    input  wire logic                      PWRITE_I,
    input  wire logic [`PPM_ADDR_W-1:0]    PADDR_I,
    input  wire logic [31:0]               PWDATA_I,
    input  wire logic [3:0]                PSTRB_I,
    output logic      [31:0]               PRDATA_O,
    output logic                           PREADY_O,
    output logic                           PSLVERR_O,

    // Group A pins
    input  wire logic [`PPM_GROUP_A_W-1:0] GROUP_A_PIN_I,
    output logic      [`PPM_GROUP_A_W-1:0] GROUP_A_PIN_O,
    output logic      [`PPM_GROUP_A_W-1:0] GROUP_A_PIN_OE_O,

    // Group E pins
    input  wire logic [`PPM_GROUP_E_W-1:0] GROUP_E_PIN_I,
    output logic      [`PPM_GROUP_E_W-1:0] GROUP_E_PIN_O,
    output logic      [`PPM_GROUP_E_W-1:0] GROUP_E_PIN_OE_O,

    // Serial peripheral interface
    input  wire logic                      SPI_EN_I,
    input  wire logic                      SPI_MASTER_I,
    input  wire logic                      SPI_FAULT_DET_I,
    input  wire logic [`PPM_SPI_W-1:0]     SPI_DO_I,
    input  wire logic [`PPM_SPI_W-1:0]     SPI_OE_I,
    output logic      [`PPM_SPI_W-1:0]     SPI_DI_O,

    // Crystal oscillator
    input  wire logic                      OSC_EN_I,
    output logic      [`PPM_GROUP_E_W-1:0] CRYSTAL_CONNECT_O,

    // Pad control
    output logic                           DEBUG_PIN_PULLUP_EN_O,
    output logic                           GROUP_E_PULLDOWN_EN_O,
    output logic                           GROUP_D_REDUCED_DRIVE_O,
    output logic                           GROUP_C_REDUCED_DRIVE_O
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    // Register state
    ppm_pkg::ppm_state_s  s_q;
    ppm_pkg::ppm_state_s  s_d;

    // Synchronised pins and function requests
    ppm_pkg::ppm_pins_t   pins_sync;
    ppm_pkg::ppm_pins_t   alt_sel;
    ppm_pkg::ppm_pins_t   alt_out;
    ppm_pkg::ppm_pins_t   alt_oe;
    ppm_pkg::ppm_pins_t   nxt_out;
    ppm_pkg::ppm_pins_t   nxt_oe;
    logic                 ss_drive;

    // Read path
    logic [7:0]           a_level;
    logic [1:0]           e_level;
    logic [7:0]           a_read;
    logic [1:0]           e_read;
    logic [31:0]          rd_word;

    // Bus decode, one strobe per register
    logic                 hit_a_data;
    logic                 hit_e_data;
    logic                 hit_a_dir;
    logic                 hit_e_dir;
    logic                 hit_pull;
    logic                 hit_drive;
    logic                 hit_a_level;
    logic                 hit_e_level;

    // Bus strobes and per-register write enables
    logic                 wr_take;
    logic                 rd_setup;
    logic [7:0]           wbyte;
    logic                 wr_a_data;
    logic                 wr_e_data;
    logic                 wr_a_dir;
    logic                 wr_e_dir;
    logic                 wr_pull;
    logic                 wr_drive;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Exact word hit; misaligned byte addresses never match
    function automatic logic reg_hit(input logic [`PPM_ADDR_W-1:0] addr,
                                     input logic [`PPM_IDX_W-1:0]  idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // Decoded once, shared by the read mux and the write path
    assign hit_a_data  = reg_hit(PADDR_I, `PPM_IDX_A_DATA);
    assign hit_e_data  = reg_hit(PADDR_I, `PPM_IDX_E_DATA);
    assign hit_a_dir   = reg_hit(PADDR_I, `PPM_IDX_A_DIR);
    assign hit_e_dir   = reg_hit(PADDR_I, `PPM_IDX_E_DIR);
    assign hit_pull    = reg_hit(PADDR_I, `PPM_IDX_PULL);
    assign hit_drive   = reg_hit(PADDR_I, `PPM_IDX_DRIVE);
    assign hit_a_level = reg_hit(PADDR_I, `PPM_IDX_A_LEVEL);
    assign hit_e_level = reg_hit(PADDR_I, `PPM_IDX_E_LEVEL);

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************

    // Two flops add two cycles of input latency, the price
    // of keeping a pin edge near the clock out of the read mux
    // Group E above group A
    ppm_sync u_sync (
        .clk_i  (CORE_CLK_I),
        .rst_i  (SYS_RST_I),
        .pins_i ({GROUP_E_PIN_I, GROUP_A_PIN_I}),
        .pins_o (pins_sync)
    );

    // Synchronised levels per group
    assign a_level = pins_sync[7:0];
    assign e_level = pins_sync[9:8];

    // ****************************************************************
    // Alternative function requests
    // ****************************************************************

    // Fault detection needs the select pin as an input
    // slave select direction
    assign ss_drive = SPI_MASTER_I & ~SPI_FAULT_DET_I;

    // Unclaimed pins fall back to GPIO in the selector
    // Upper group A pins have no alternative function
    always_comb begin
        alt_sel = '0;
        alt_out = '0;
        alt_oe  = '0;
        alt_sel[3:0] = {4{SPI_EN_I}};
        alt_out[2:0] = SPI_DO_I[2:0];
        alt_oe[2:0]  = SPI_OE_I[2:0];
        alt_out[`PPM_SPI_SS_BIT] = SPI_DO_I[`PPM_SPI_SS_BIT];
        alt_oe[`PPM_SPI_SS_BIT]  = ss_drive;
        alt_sel[9:8] = {2{OSC_EN_I}};
    end

    // ****************************************************************
    // Function selector
    // ****************************************************************

    // Priority sits in one place so a new function slots in
    // fixed priority per pin
    ppm_pin_mux #(
        .W (10)
    ) u_mux (
        .gpio_out_i ({s_q.e_data, s_q.a_data}),
        .gpio_dir_i ({s_q.e_dir,  s_q.a_dir}),
        .alt_sel_i  (alt_sel),
        .alt_out_i  (alt_out),
        .alt_oe_i   (alt_oe),
        .pin_out_o  (nxt_out),
        .pin_oe_o   (nxt_oe)
    );

    // ****************************************************************
    // Data read path
    // ****************************************************************

    // latch when output, pin when input
    assign a_read = (s_q.a_dir & s_q.a_data) | (~s_q.a_dir & a_level);
    assign e_read = (s_q.e_dir & s_q.e_data) | (~s_q.e_dir & e_level);

    // Read word for the addressed register
    always_comb begin
        rd_word = '0;
        if (hit_a_data) begin
            rd_word[7:0] = a_read;
        end
        if (hit_e_data) begin
            rd_word[1:0] = e_read;
        end
        if (hit_a_dir) begin
            rd_word[7:0] = s_q.a_dir;
        end
        if (hit_e_dir) begin
            rd_word[1:0] = s_q.e_dir;
        end
        if (hit_pull) begin
            rd_word[`PPM_PULL_DBG_PU_BIT] = s_q.dbg_pu;
            rd_word[`PPM_PULL_E_PD_BIT]   = s_q.e_pd;
        end
        if (hit_drive) begin
            rd_word[`PPM_DRV_D_BIT] = s_q.d_rd;
            rd_word[`PPM_DRV_C_BIT] = s_q.c_rd;
        end
        if (hit_a_level) begin
            rd_word[7:0] = a_level;
        end
        if (hit_e_level) begin
            rd_word[1:0] = e_level;
        end
    end

    // ****************************************************************
    // Bus strobes
    // ****************************************************************

    // Only byte lane 0 carries register data
    assign wr_take  = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0];
    assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign wbyte    = PWDATA_I[7:0];

    // Level registers get no enable, so writes to them fall away
    // no enable for levels
    assign wr_a_data = wr_take & hit_a_data;
    assign wr_e_data = wr_take & hit_e_data;
    assign wr_a_dir  = wr_take & hit_a_dir;
    assign wr_e_dir  = wr_take & hit_e_dir;
    assign wr_pull   = wr_take & hit_pull;
    assign wr_drive  = wr_take & hit_drive;

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Registers, read capture and pad drive
    always_comb begin
        s_d = s_q;
        // Writes land at the access edge
        if (wr_a_data) begin
            s_d.a_data = wbyte;
        end
        if (wr_e_data) begin
            s_d.e_data = wbyte[1:0];
        end
        if (wr_a_dir) begin
            s_d.a_dir = wbyte;
        end
        if (wr_e_dir) begin
            s_d.e_dir = wbyte[1:0];
        end
        if (wr_pull) begin
            s_d.dbg_pu = wbyte[`PPM_PULL_DBG_PU_BIT];
            s_d.e_pd   = wbyte[`PPM_PULL_E_PD_BIT];
        end
        if (wr_drive) begin
            s_d.d_rd = wbyte[`PPM_DRV_D_BIT];
            s_d.c_rd = wbyte[`PPM_DRV_C_BIT];
        end

        // Captured at setup so the slave never needs a wait state
        // unmapped and reserved read zero
        if (rd_setup) begin
            s_d.rdata = rd_word;
        end

        // Registered pad drive costs one cycle of latency
        // but keeps decode glitches off the pads
        s_d.pin_out  = nxt_out;
        s_d.pin_oe   = nxt_oe;
        s_d.osc_conn = {2{OSC_EN_I}};

        if (SYS_RST_I) begin
            s_d        = '0;
            s_d.a_data = `PPM_RST_A_BYTE;
            s_d.a_dir  = `PPM_RST_A_BYTE;
            s_d.e_data = `PPM_RST_E_BITS;
            s_d.e_dir  = `PPM_RST_E_BITS;
            s_d.dbg_pu = `PPM_RST_DBG_PU;
            s_d.e_pd   = `PPM_RST_E_PD;
            s_d.d_rd   = `PPM_RST_D_RD;
            s_d.c_rd   = `PPM_RST_C_RD;
        end
    end

    // No asynchronous reset: pads are unknown until the first edge
    // State register, reset folded into the next state
    always_ff @(posedge CORE_CLK_I) begin
        s_q <= s_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Bus answer: read word captured in setup, no wait states
    // A write leaves the captured read word alone
    assign PRDATA_O  = s_q.rdata;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = 1'b0;

    // ****************************************************************
    // Pad and function outputs
    // ****************************************************************

    // Pads
    assign GROUP_A_PIN_O    = s_q.pin_out[7:0];
    assign GROUP_A_PIN_OE_O = s_q.pin_oe[7:0];
    assign GROUP_E_PIN_O    = s_q.pin_out[9:8];
    assign GROUP_E_PIN_OE_O = s_q.pin_oe[9:8];

    // SPI inputs always see the synchronised pins
    assign SPI_DI_O = a_level[3:0];

    // Crystal hookup follows the enable one edge late
    assign CRYSTAL_CONNECT_O       = s_q.osc_conn;

    // Pad control straight from the registers
    assign DEBUG_PIN_PULLUP_EN_O   = s_q.dbg_pu;
    assign GROUP_E_PULLDOWN_EN_O   = s_q.e_pd;
    assign GROUP_D_REDUCED_DRIVE_O = s_q.d_rd;
    assign GROUP_C_REDUCED_DRIVE_O = s_q.c_rd;

endmodule // ppm_port_mux_gpio

`default_nettype wire

// ===== ppm_port_mux_gpio_props.sv
`default_nettype none
`include "ppm_cfg.svh"

// ****************************************************************
// Port mux checker
// ****************************************************************
module ppm_props (
    // Clock, reset and bus
    input  wire logic        CORE_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [10:0] PADDR_I,
    input  wire logic [31:0] PRDATA_O,
    // Pins and functions
    input  wire logic [7:0]  GROUP_A_PIN_O,
    input  wire logic [7:0]  GROUP_A_PIN_OE_O,
    input  wire logic [1:0]  GROUP_E_PIN_OE_O,
    input  wire logic        SPI_EN_I,
    input  wire logic        SPI_MASTER_I,
    input  wire logic        SPI_FAULT_DET_I,
    input  wire logic [3:0]  SPI_DO_I,
    input  wire logic [3:0]  SPI_OE_I,
    input  wire logic        OSC_EN_I,
    input  wire logic [1:0]  CRYSTAL_CONNECT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // Read setup decode; misaligned counts as unmapped
    wire logic       rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
    wire logic [8:0] idx      = PADDR_I[10:2];
    wire logic       mapped   = (PADDR_I[1:0] == 2'h0) && (idx inside {`PPM_IDX_A_DATA, `PPM_IDX_E_DATA,
        `PPM_IDX_A_DIR, `PPM_IDX_E_DIR, `PPM_IDX_PULL, `PPM_IDX_DRIVE, `PPM_IDX_A_LEVEL, `PPM_IDX_E_LEVEL});
    wire logic       ss_out   = SPI_MASTER_I && !SPI_FAULT_DET_I;

    a_reset_gpi: assert property (disable iff (1'b0) SYS_RST_I |=> GROUP_A_PIN_OE_O == 8'h00
        && GROUP_E_PIN_OE_O == 2'h0) else $error("pins driven after reset");
    a_ss_master_out: assert property (SPI_EN_I && ss_out |=> GROUP_A_PIN_OE_O[3]
        && GROUP_A_PIN_O[3] == $past(SPI_DO_I[3])) else $error("slave select not driven in master mode");
    a_ss_input: assert property (SPI_EN_I && !ss_out |=> !GROUP_A_PIN_OE_O[3])
        else $error("slave select driven while input");
    a_sck_spi_owns: assert property (SPI_EN_I |=> GROUP_A_PIN_OE_O[2] == $past(SPI_OE_I[2])
        && GROUP_A_PIN_O[2] == $past(SPI_DO_I[2])) else $error("clock pin not given to spi");
    a_mosi_spi_owns: assert property (SPI_EN_I |=> GROUP_A_PIN_OE_O[1] == $past(SPI_OE_I[1])
        && GROUP_A_PIN_O[1] == $past(SPI_DO_I[1])) else $error("mosi pin not given to spi");
    a_miso_spi_owns: assert property (SPI_EN_I |=> GROUP_A_PIN_OE_O[0] == $past(SPI_OE_I[0])
        && GROUP_A_PIN_O[0] == $past(SPI_DO_I[0])) else $error("miso pin not given to spi");
    a_crystal_owns: assert property (OSC_EN_I |=> GROUP_E_PIN_OE_O == 2'h0 && CRYSTAL_CONNECT_O == 2'h3)
        else $error("crystal pins not released");
    a_rsvd_zero: assert property (rd_setup && !mapped |=> PRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (PRDATA_O[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_narrow_zero: assert property (rd_setup && (idx inside {`PPM_IDX_E_DATA, `PPM_IDX_E_DIR,
        `PPM_IDX_E_LEVEL}) |=> PRDATA_O[7:2] == 6'h00) else $error("group E unused bits not zero");

    // Main scenarios reached
    c_spi_master: cover property (SPI_EN_I && ss_out);
    c_osc_on: cover property (OSC_EN_I);
    c_rsvd_read: cover property (rd_setup && !mapped);
endmodule // ppm_props

bind ppm_port_mux_gpio ppm_props u_props (.*);

`default_nettype wire

// ===== ppm_sync.sv
`default_nettype none

// ****************************************************************
// Two-flop pin synchroniser
// ****************************************************************
module ppm_sync (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Raw and synchronised levels
    input  wire ppm_pkg::ppm_pins_t pins_i,
    output var  ppm_pkg::ppm_pins_t pins_o
);

    ppm_pkg::ppm_sync_s s_q;
    ppm_pkg::ppm_sync_s s_d;

    // Meta stage feeds only the stable stage
    always_comb begin
        s_d = s_q;
        s_d.meta   = pins_i;
        s_d.stable = s_q.meta;
        if (rst_i) begin
            s_d = '0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign pins_o = s_q.stable;

endmodule // ppm_sync

`default_nettype wire

// ===== tb.sv
`default_nettype none
`include "ppm_cfg.svh"

// ****************************************************************
// Port mux testbench
// ****************************************************************
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Design ports and outside pin sources
    logic        CORE_CLK_I = 1'b0, SYS_RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic [10:0] PADDR_I = 11'h000;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O;
    logic [3:0]  PSTRB_I = 4'hF, SPI_DO_I = 4'hA, SPI_OE_I = 4'h5, SPI_DI_O;
    logic        PREADY_O, PSLVERR_O, SPI_EN_I = 1'b0, SPI_MASTER_I = 1'b0, SPI_FAULT_DET_I = 1'b0, OSC_EN_I = 1'b0;
    logic [7:0]  GROUP_A_PIN_I, GROUP_A_PIN_O, GROUP_A_PIN_OE_O, ext_a = 8'hC3;
    logic [1:0]  GROUP_E_PIN_I, GROUP_E_PIN_O, GROUP_E_PIN_OE_O, CRYSTAL_CONNECT_O, ext_e = 2'h2;
    logic        DEBUG_PIN_PULLUP_EN_O, GROUP_E_PULLDOWN_EN_O, GROUP_D_REDUCED_DRIVE_O, GROUP_C_REDUCED_DRIVE_O;
    logic [8:0]  rsvd_idx [5] = '{9'h004, 9'h009, 9'h00A, 9'h122, 9'h17F};
    logic [1:0]  mode [3] = '{2'h2, 2'h3, 2'h0};
    logic        oe3;
    int          num_errors = 0, cmp_count = 0, cycles = 0;

    ppm_port_mux_gpio DUT (.*);
    ppm_pin_model u_pins (
        .pin_o_i  ({GROUP_E_PIN_O, GROUP_A_PIN_O}),
        .pin_oe_i ({GROUP_E_PIN_OE_O, GROUP_A_PIN_OE_O}),
        .ext_i    ({ext_e, ext_a}),
        .pin_i_o  ({GROUP_E_PIN_I, GROUP_A_PIN_I})
    );

    // Clock
    always #5 CORE_CLK_I = ~CORE_CLK_I;

    // Hang guard, far above the 160 or so cycles needed
    always @(posedge CORE_CLK_I) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits on pready rather than assuming it
    task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge CORE_CLK_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= wr;
        PADDR_I <= {idx, 2'b00};
        PWDATA_I <= {24'h0, wd};
        @(posedge CORE_CLK_I);
        PENABLE_I <= 1'b1;
        @(posedge CORE_CLK_I);
        while (PREADY_O !== 1'b1) @(posedge CORE_CLK_I);
        rd = PRDATA_O;
        check("pslverr", {31'h0, PSLVERR_O}, 32'h0);
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, idx, d, r);
    endtask

    task automatic rdc(input string what, input logic [8:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, idx, 8'h00, r);
        check(what, r, exp);
    endtask

    // Lets pin drive and the synchroniser settle
    task automatic settle;
        repeat (4) @(posedge CORE_CLK_I);
        #1;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge CORE_CLK_I);
        SYS_RST_I <= 1'b0;
        settle();
        check("oe", {GROUP_E_PIN_OE_O, GROUP_A_PIN_OE_O}, 32'h0);
        rdc("dir_a", `PPM_IDX_A_DIR, 32'h0);
        rdc("dir_e", `PPM_IDX_E_DIR, 32'h0);
        rdc("data_a", `PPM_IDX_A_DATA, 32'hC3);
        rdc("data_e", `PPM_IDX_E_DATA, 32'h2);
        rdc("pull", `PPM_IDX_PULL, 32'h0);
        rdc("drive", `PPM_IDX_DRIVE, 32'h0);
        $display("test reset done");
        // Mixed direction: low nibble latch, high nibble pin
        wr(`PPM_IDX_A_DIR, 8'h0F);
        wr(`PPM_IDX_A_DATA, 8'h5A);
        settle();
        check("a_oe", GROUP_A_PIN_OE_O, 32'h0F);
        check("a_out", GROUP_A_PIN_O & 8'h0F, 32'h0A);
        rdc("data_a", `PPM_IDX_A_DATA, 32'hCA);
        rdc("level_a", `PPM_IDX_A_LEVEL, 32'hCA);
        wr(`PPM_IDX_A_LEVEL, 8'h00);
        rdc("level_a", `PPM_IDX_A_LEVEL, 32'hCA);
        rdc("level_e", `PPM_IDX_E_LEVEL, 32'h2);
        $display("test gpio done");
        // Reserved space and unimplemented bits
        foreach (rsvd_idx[i]) begin
            wr(rsvd_idx[i], 8'hFF);
            rdc("reserved", rsvd_idx[i], 32'h0);
        end
        wr(`PPM_IDX_E_DATA, 8'hFF);
        wr(`PPM_IDX_E_DIR, 8'hFF);
        wr(`PPM_IDX_PULL, 8'hFF);
        wr(`PPM_IDX_DRIVE, 8'hFF);
        rdc("dir_e", `PPM_IDX_E_DIR, 32'h3);
        rdc("data_e", `PPM_IDX_E_DATA, 32'h3);
        rdc("pull", `PPM_IDX_PULL, 32'h42);
        rdc("drive", `PPM_IDX_DRIVE, 32'h0C);
        // Strobe low write must not land
        PSTRB_I <= 4'h0;
        wr(`PPM_IDX_PULL, 8'h00);
        PSTRB_I <= 4'hF;
        rdc("pull", `PPM_IDX_PULL, 32'h42);
        check("pads", {DEBUG_PIN_PULLUP_EN_O, GROUP_E_PULLDOWN_EN_O, GROUP_D_REDUCED_DRIVE_O,
            GROUP_C_REDUCED_DRIVE_O}, 32'hF);
        $display("test reserved done");
        // Crystal takes group E over GPIO outputs
        check("e_gpio", {GROUP_E_PIN_OE_O, GROUP_E_PIN_O}, 32'hF);
        OSC_EN_I <= 1'b1;
        settle();
        check("e_osc", {GROUP_E_PIN_OE_O, CRYSTAL_CONNECT_O}, 32'h3);
        @(posedge CORE_CLK_I);
        OSC_EN_I <= 1'b0;
        settle();
        check("e_back", {GROUP_E_PIN_OE_O, GROUP_E_PIN_O, CRYSTAL_CONNECT_O}, 32'h3C);
        $display("test osc done");
        // SPI over all-output GPIO in each slave select mode
        wr(`PPM_IDX_A_DIR, 8'hFF);
        wr(`PPM_IDX_A_DATA, 8'h00);
        foreach (mode[i]) begin
            @(posedge CORE_CLK_I);
            oe3 = mode[i] == 2'h2;
            SPI_EN_I <= 1'b1;
            SPI_MASTER_I <= mode[i][1];
            SPI_FAULT_DET_I <= mode[i][0];
            settle();
            check("spi_oe", GROUP_A_PIN_OE_O, {4'hF, oe3, 3'h5});
            check("spi_out", {GROUP_A_PIN_O[3] & oe3, GROUP_A_PIN_O[2:0]}, {oe3, 3'h2});
            check("spi_in", SPI_DI_O, {oe3, 3'h2});
        end
        @(posedge CORE_CLK_I);
        SPI_EN_I <= 1'b0;
        settle();
        check("gpio_back", GROUP_A_PIN_OE_O, 32'hFF);
        $display("test spi done");
        // Reset in mid-run returns reconfigured pins to inputs
        @(posedge CORE_CLK_I);
        SYS_RST_I <= 1'b1;
        repeat (2) @(posedge CORE_CLK_I);
        SYS_RST_I <= 1'b0;
        settle();
        check("oe_rst", {GROUP_E_PIN_OE_O, GROUP_A_PIN_OE_O}, 32'h0);
        rdc("dir_a_rst", `PPM_IDX_A_DIR, 32'h0);
        $display("test reset again done");
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
